// ---- verilog/segment_address_generator.sv ----
`timescale 1ns/10ps
module segment_address_generator
   import seg_addr_pkg::*;
#(
   parameter int SEG_COUNT = NUM_SEG
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reqValid,
   input wire logic [2:0] reqType,
   input wire logic protMode,
   input wire logic pagingOn,
   input wire logic addr16,
   input wire logic overrideEn,
   input wire logic [2:0] overrideSeg,
   input wire logic baseEn,
   input wire logic [2:0] baseSel,
   input wire logic [31:0] baseVal,
   input wire logic indexEn,
   input wire logic [31:0] indexVal,
   input wire logic [1:0] scale,
   input wire logic [31:0] disp,
   input wire logic [1:0] dispSize,
   input wire logic [31:0] ipVal,
   input wire logic [31:0] destIdx,
   input wire logic portImmEn,
   input wire logic [7:0] portImm,
   input wire logic [15:0] portAddrReg,
   input wire logic [1:0] accSize,
   input wire logic [31:0] wrData,
   input wire logic [2:0] fieldPos,
   input wire logic [5:0] fieldWidth,
   input wire logic segWrEn,
   input wire logic [2:0] segWrIdx,
   input wire logic [15:0] segWrSel,
   input wire logic [31:0] segWrBase,
   input wire logic [31:0] segWrLimit,
   output logic busValid,
   output logic [31:0] busAddr,
   output logic memIoSel,
   output logic [3:0] byteEn,
   output logic [31:0] busData,
   output logic splitNeeded,
   output logic linValid,
   output logic [31:0] linAddr,
   output logic [19:0] pageNum,
   output logic [11:0] pageOff,
   output logic [2:0] segUsed,
   output logic protFault,
   output logic fieldFault,
   output logic [2:0] fieldBytes,
   output logic bcdOk
);
   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (SEG_COUNT != NUM_SEG)
      $error("segment count must be six");

   // ****************************************************************
   // segment state
   // ****************************************************************
   logic [15:0] selReg [SEG_COUNT];
   logic [31:0] baseReg [SEG_COUNT];
   logic [31:0] limitReg [SEG_COUNT];
   logic [15:0] selNext [SEG_COUNT];
   logic [31:0] baseNext [SEG_COUNT];
   logic [31:0] limitNext [SEG_COUNT];

   always_comb
   begin
      selNext = selReg;
      baseNext = baseReg;
      limitNext = limitReg;
      // no cross-check of bases: any overlap, even all zero, is legal
      if (segWrEn && (segWrIdx < 3'(SEG_COUNT)))
      begin
         selNext[segWrIdx] = segWrSel;
         baseNext[segWrIdx] = segWrBase;
         limitNext[segWrIdx] = segWrLimit;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         selReg <= '{default: SEL_RESET};
         baseReg <= '{default: BASE_RESET};
         limitReg <= '{default: LIMIT_RESET};
      end
      else
      begin
         selReg <= selNext;
         baseReg <= baseNext;
         limitReg <= limitNext;
      end
   end

   // ****************************************************************
   // effective address
   // ****************************************************************
   ea_if eaBus ();
   logic isCode;
   logic isStack;
   logic isStrDst;
   logic isPort;

   assign isCode = (reqType == REF_CODE);
   assign isStack = (reqType == REF_PUSH) || (reqType == REF_POP);
   assign isStrDst = (reqType == REF_STR_DST);
   assign isPort = (reqType == REF_PORT_RD) || (reqType == REF_PORT_WR);

   always_comb
   begin
      eaBus.addr16 = addr16;
      eaBus.scale = scale;
      eaBus.indexVal = indexVal;
      eaBus.disp = disp;
      eaBus.baseEn = baseEn;
      eaBus.baseVal = baseVal;
      eaBus.indexEn = indexEn;
      eaBus.dispSize = dispSize;
      if (isCode || isStrDst)
      begin
         eaBus.baseVal = isCode ? ipVal : destIdx;
         eaBus.baseEn = 1'b1;
         eaBus.indexEn = 1'b0;
         eaBus.dispSize = DISP_NONE;
      end
   end

   ea_calc eaUnit
   (
      .eaBus(eaBus)
   );

   // ****************************************************************
   // segment choice, translation and checks
   // ****************************************************************
   logic [2:0] segSel;
   logic [31:0] linear;
   logic [31:0] portAddr;
   logic [31:0] lastOff;
   logic memFault;
   logic [2:0] sizeBytes;
   logic [3:0] sizeMask;
   logic [3:0] laneSum;
   logic [6:0] fieldEnd;
   logic [2:0] fieldSpan;

   always_comb
   begin
      if (isCode)
         segSel = SEG_CODE;
      else if (isStack)
         segSel = SEG_STACK;
      else if (isStrDst)
         segSel = SEG_EXTRA;
      else if (overrideEn && (overrideSeg < 3'(SEG_COUNT)))
         segSel = overrideSeg;
      else if (baseEn &&
               (baseSel == GP_FRAME_BASE || baseSel == GP_STACK_PTR))
         segSel = SEG_STACK;
      else
         segSel = SEG_DATA;

      if (protMode)
         linear = baseReg[segSel] + eaBus.ea;
      else
         linear = ({16'h0000, selReg[segSel]} << REAL_SHIFT)
                  + eaBus.ea;

      sizeBytes = (accSize == SIZE_DWORD) ? 3'h4
                  : (accSize == SIZE_WORD) ? 3'h2 : 3'h1;
      sizeMask = 4'((5'h01 << sizeBytes) - 5'h01);
      lastOff = eaBus.ea + 32'(sizeBytes) - 32'h00000001;

      // limit is size minus one, so 0 gives one byte, all ones 4G
      if (!protMode)
         memFault = !addr16 && (eaBus.ea > REAL_OFFSET_MAX);
      else
         memFault = (eaBus.ea > limitReg[segSel]) ||
                    (lastOff > limitReg[segSel]) ||
                    (lastOff < eaBus.ea);

      // 64K space; short addresses zero-extended onto upper lines
      if (portImmEn)
         portAddr = {24'h000000, portImm};
      else
         portAddr = {16'h0000, portAddrReg};

      fieldEnd = 7'(fieldPos) + 7'(fieldWidth) + 7'h07;
      fieldSpan = fieldEnd[5:3];
      // width 0 or above 32 is not a legal field
      if (fieldWidth == 6'h00 || fieldWidth > 6'(FIELD_MAX_BITS))
         fieldSpan = 3'h0;
   end

   // ****************************************************************
   // registered bus outputs
   // ****************************************************************
   logic busValidNext;
   logic [31:0] busAddrNext;
   logic memIoSelNext;
   logic [3:0] byteEnNext;
   logic [31:0] busDataNext;
   logic splitNext;
   logic linValidNext;
   logic [31:0] linAddrNext;
   logic [2:0] segUsedNext;
   logic protFaultNext;
   logic fieldFaultNext;
   logic bcdOkNext;
   logic [2:0] fieldBytesNext;
   logic [31:0] outAddr;

   always_comb
   begin
      outAddr = isPort ? portAddr : linear;
      busValidNext = 1'b0;
      busAddrNext = busAddr;
      memIoSelNext = memIoSel;
      byteEnNext = byteEn;
      busDataNext = busData;
      splitNext = splitNeeded;
      linValidNext = 1'b0;
      linAddrNext = linAddr;
      segUsedNext = segUsed;
      protFaultNext = 1'b0;
      fieldFaultNext = fieldFault;
      bcdOkNext = bcdOk;
      fieldBytesNext = fieldBytes;
      laneSum = 4'(outAddr[1:0]) + 4'(sizeBytes);
      if (reqValid)
      begin
         segUsedNext = segSel;
         // low byte on lane outAddr[1:0]; higher bytes on higher addresses
         byteEnNext = 4'(sizeMask << outAddr[1:0]);
         busDataNext = wrData << {outAddr[1:0], 3'b000};
         splitNext = laneSum > 4'h4;
         fieldFaultNext = (fieldSpan == 3'h0) ||
                          (fieldSpan > 3'(FIELD_MAX_BYTES));
         fieldBytesNext = fieldSpan;
         bcdOkNext = (wrData[3:0] <= BCD_MAX_DIGIT) &&
                     (wrData[7:4] <= BCD_MAX_DIGIT);
         if (isPort)
         begin
            busValidNext = 1'b1;
            busAddrNext = portAddr;
            memIoSelNext = 1'b0;
         end
         else if (memFault)
            protFaultNext = 1'b1;
         else
         begin
            memIoSelNext = 1'b1;
            linAddrNext = linear;
            // with paging on, the paging unit owns the pins
            if (pagingOn)
               linValidNext = 1'b1;
            else
            begin
               busValidNext = 1'b1;
               busAddrNext = linear;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         busValid <= 1'b0;
         busAddr <= 32'h00000000;
         memIoSel <= 1'b1;
         byteEn <= 4'h0;
         busData <= 32'h00000000;
         splitNeeded <= 1'b0;
         linValid <= 1'b0;
         linAddr <= 32'h00000000;
         segUsed <= SEG_DATA;
         protFault <= 1'b0;
         fieldFault <= 1'b0;
         fieldBytes <= 3'h0;
         bcdOk <= 1'b0;
         pageNum <= 20'h00000;
         pageOff <= 12'h000;
      end
      else
      begin
         busValid <= busValidNext;
         busAddr <= busAddrNext;
         memIoSel <= memIoSelNext;
         byteEn <= byteEnNext;
         busData <= busDataNext;
         splitNeeded <= splitNext;
         linValid <= linValidNext;
         linAddr <= linAddrNext;
         segUsed <= segUsedNext;
         protFault <= protFaultNext;
         fieldFault <= fieldFaultNext;
         fieldBytes <= fieldBytesNext;
         bcdOk <= bcdOkNext;
         pageNum <= linAddrNext[31:PAGE_SHIFT];
         pageOff <= linAddrNext[PAGE_SHIFT-1:0];
      end
   end
endmodule

// ---- verilog/seg_addr_pkg.sv ----
package seg_addr_pkg;
   // ****************************************************************
   // segment register indices
   // ****************************************************************
   localparam logic [2:0] SEG_EXTRA = 3'h0;
   localparam logic [2:0] SEG_CODE = 3'h1;
   localparam logic [2:0] SEG_STACK = 3'h2;
   localparam logic [2:0] SEG_DATA = 3'h3;
   localparam logic [2:0] SEG_EXTRA2 = 3'h4;
   localparam logic [2:0] SEG_EXTRA3 = 3'h5;
   localparam int NUM_SEG = 6;

   // ****************************************************************
   // reference type codes on reqType
   // ****************************************************************
   localparam logic [2:0] REF_CODE = 3'h0;
   localparam logic [2:0] REF_PUSH = 3'h1;
   localparam logic [2:0] REF_POP = 3'h2;
   localparam logic [2:0] REF_STR_DST = 3'h3;
   localparam logic [2:0] REF_DATA = 3'h4;
   localparam logic [2:0] REF_PORT_RD = 3'h5;
   localparam logic [2:0] REF_PORT_WR = 3'h6;

   // ****************************************************************
   // general register numbers that steer the default segment
   // ****************************************************************
   localparam logic [2:0] GP_STACK_PTR = 3'h4;
   localparam logic [2:0] GP_FRAME_BASE = 3'h5;

   // ****************************************************************
   // displacement and access size codes
   // ****************************************************************
   localparam logic [1:0] DISP_NONE = 2'h0;
   localparam logic [1:0] DISP_8 = 2'h1;
   localparam logic [1:0] DISP_16 = 2'h2;
   localparam logic [1:0] DISP_32 = 2'h3;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_DWORD = 2'h2;

   // ****************************************************************
   // address space constants
   // ****************************************************************
   localparam int REAL_SHIFT = 4;
   localparam int PAGE_SHIFT = 12;
   localparam logic [31:0] REAL_OFFSET_MAX = 32'h0000FFFF;
   localparam logic [15:0] IO_RESERVED_LO = 16'h00F8;
   localparam logic [15:0] IO_RESERVED_HI = 16'h00FF;
   localparam int FIELD_MAX_BITS = 32;
   localparam int FIELD_MAX_BYTES = 4;
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;

   // ****************************************************************
   // reset values of segment state
   // ****************************************************************
   localparam logic [15:0] SEL_RESET = 16'h0000;
   localparam logic [31:0] BASE_RESET = 32'h00000000;
   localparam logic [31:0] LIMIT_RESET = 32'hFFFFFFFF;
endpackage

// ---- verilog/ea_if.sv ----
`timescale 1ns/10ps
interface ea_if;
   logic baseEn;
   logic [31:0] baseVal;
   logic indexEn;
   logic [31:0] indexVal;
   logic [1:0] scale;
   logic [31:0] disp;
   logic [1:0] dispSize;
   logic addr16;
   logic [31:0] ea;

   modport calc
   (
      input baseEn, baseVal, indexEn, indexVal, scale, disp, dispSize,
      input addr16,
      output ea
   );
   modport user
   (
      output baseEn, baseVal, indexEn, indexVal, scale, disp, dispSize,
      output addr16,
      input ea
   );
endinterface

// ---- verilog/ea_calc.sv ----
`timescale 1ns/10ps
module ea_calc
   import seg_addr_pkg::*;
(
   ea_if.calc eaBus
);
   logic [31:0] dispExt;
   logic [31:0] baseTerm;
   logic [31:0] indexTerm;
   logic [31:0] sum;

   always_comb
   begin
      // displacement is two's complement, sign-extended to full width
      case (eaBus.dispSize)
         DISP_8:
            dispExt = {{24{eaBus.disp[7]}}, eaBus.disp[7:0]};
         DISP_16:
            dispExt = {{16{eaBus.disp[15]}}, eaBus.disp[15:0]};
         DISP_32:
            dispExt = eaBus.disp;
         default:
            dispExt = 32'h00000000;
      endcase
      baseTerm = eaBus.baseEn ? eaBus.baseVal : 32'h00000000;
      // 16-bit addressing has no scaling
      if (!eaBus.indexEn)
         indexTerm = 32'h00000000;
      else if (eaBus.addr16)
         indexTerm = eaBus.indexVal;
      else
         indexTerm = eaBus.indexVal << eaBus.scale;
      sum = baseTerm + indexTerm + dispExt;
      // 16-bit offsets wrap inside 64K
      eaBus.ea = eaBus.addr16 ? {16'h0000, sum[15:0]} : sum;
   end
endmodule

// ---- sim/seg_addr_chk.sv ----
`timescale 1ns/10ps
module seg_addr_chk
   import seg_addr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reqValid,
   input wire logic [2:0] reqType,
   input wire logic portImmEn,
   input wire logic [7:0] portImm,
   input wire logic [1:0] accSize,
   input wire logic busValid,
   input wire logic [31:0] busAddr,
   input wire logic memIoSel,
   input wire logic [3:0] byteEn,
   input wire logic [2:0] segUsed,
   input wire logic linValid,
   input wire logic protFault
);
   // ****************************************************************
   // request to answer relations
   // ****************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic isPort;
   assign isPort = reqType == REF_PORT_RD || reqType == REF_PORT_WR;

   chk_one_answer: assert property (
      reqValid |=> $onehot({busValid, linValid, protFault}))
      else $error("request not answered by exactly one pulse");
   chk_idle_quiet: assert property (
      !reqValid |=> !busValid && !linValid && !protFault)
      else $error("answer pulse without a request");
   chk_port_space: assert property (
      reqValid && isPort |=> busValid && !memIoSel && busAddr[31:16] == 16'h0)
      else $error("port cycle not in the port space");
   chk_port_imm: assert property (
      reqValid && isPort && portImmEn |=> busAddr == {24'h0, $past(portImm)})
      else $error("immediate port address not zero extended");
   chk_mem_space: assert property (
      reqValid && !isPort |=> !busValid || memIoSel)
      else $error("memory cycle flagged as port");
   chk_fetch_seg: assert property (
      reqValid && reqType == REF_CODE |=> protFault || segUsed == SEG_CODE)
      else $error("fetch not on the code segment");
   chk_stack_seg: assert property (
      reqValid && (reqType == REF_PUSH || reqType == REF_POP)
      |=> protFault || segUsed == SEG_STACK)
      else $error("stack access not on the stack segment");
   chk_word_lanes: assert property (
      busValid && $past(accSize) == SIZE_WORD
      |-> byteEn == 4'(4'h3 << busAddr[1:0]))
      else $error("word lanes not at its address");

   cover property (reqValid && isPort ##1 busValid);
   cover property (protFault);
   cover property (linValid);
endmodule

bind segment_address_generator seg_addr_chk i_chk (.clk, .rst_n,
   .reqValid, .reqType, .portImmEn, .portImm, .accSize, .busValid,
   .busAddr, .memIoSel, .byteEn, .segUsed, .linValid, .protFault);

// ---- sim/bus_peer.sv ----
`timescale 1ns/10ps
module bus_peer
(
   input wire logic clk,
   input wire logic busValid,
   input wire logic [31:0] busAddr,
   input wire logic memIoSel,
   input wire logic [3:0] byteEn,
   input wire logic [31:0] busData
);
   // ****************************************************************
   // byte stores of both spaces
   // ****************************************************************
   logic [7:0] memByte [logic [31:0]];
   logic [7:0] portByte [logic [15:0]];
   logic resvHit = 1'b0;
   // nothing decodes the reserved ports, so such cycles are only noted
   always @(posedge clk)
      if (busValid)
         for (int i = 0; i < 4; i++)
            if (byteEn[i] && memIoSel)
               memByte[{busAddr[31:2], 2'b00} + 32'(i)] = busData[8*i +: 8];
            else if (byteEn[i] && busAddr[15:3] == 13'h1F)
               resvHit = 1'b1;
            else if (byteEn[i])
               portByte[{busAddr[15:2], 2'b00} + 16'(i)] = busData[8*i +: 8];
endmodule

// ---- sim/segment_address_generator_test.sv ----
`timescale 1ns/10ps
`define CHK(a, e) \
   begin \
      checks++; \
      if ((a) !== (e)) \
      begin \
         failures++; \
         $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); \
      end \
   end
module segment_address_generator_test
   import seg_addr_pkg::*;
();
   // ****************************************************************
   // stimulus and scenarios
   // ****************************************************************
   int failures = 0;
   int checks = 0;
   logic clk, rst_n, reqValid, protMode, pagingOn, addr16, overrideEn;
   logic baseEn, indexEn, portImmEn, segWrEn, bad;
   logic busValid, memIoSel, splitNeeded, linValid, protFault;
   logic fieldFault, bcdOk;
   logic [1:0] scale, dispSize, accSize;
   logic [2:0] reqType, overrideSeg, baseSel, fieldPos, segWrIdx, want;
   logic [2:0] segUsed, fieldBytes;
   logic [3:0] byteEn;
   logic [5:0] fieldWidth;
   logic [7:0] portImm;
   logic [11:0] pageOff;
   logic [15:0] portAddrReg, segWrSel;
   logic [19:0] pageNum;
   logic [31:0] baseVal, indexVal, disp, ipVal, destIdx, wrData;
   logic [31:0] segWrBase, segWrLimit, busAddr, busData, linAddr;
   int n;

   segment_address_generator i_dut (.clk, .rst_n, .reqValid, .reqType,
      .protMode, .pagingOn, .addr16, .overrideEn, .overrideSeg, .baseEn,
      .baseSel, .baseVal, .indexEn, .indexVal, .scale, .disp, .dispSize,
      .ipVal, .destIdx, .portImmEn, .portImm, .portAddrReg, .accSize,
      .wrData, .fieldPos, .fieldWidth, .segWrEn, .segWrIdx, .segWrSel,
      .segWrBase, .segWrLimit, .busValid, .busAddr, .memIoSel, .byteEn,
      .busData, .splitNeeded, .linValid, .linAddr, .pageNum, .pageOff,
      .segUsed, .protFault, .fieldFault, .fieldBytes, .bcdOk);
   bus_peer i_peer (.clk, .busValid, .busAddr, .memIoSel, .byteEn,
      .busData);

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [31:0] sb(input int z, input int k);
      return z ? 32'h0 : 32'(k + 1) << 24;
   endfunction

   task automatic wrap_up;
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic ea(input logic [31:0] b, input logic [31:0] d);
      @(posedge clk);
      baseVal <= b;
      disp <= d;
   endtask

   // called at an edge; answers are read 1 ns after the next edge
   task automatic req(input logic [2:0] t);
      reqType <= t;
      reqValid <= 1'b1;
      @(posedge clk);
      reqValid <= 1'b0;
      #1;
   endtask

   task automatic seg(input logic [2:0] x, input logic [15:0] s,
      input logic [31:0] b, input logic [31:0] l);
      @(posedge clk);
      segWrEn <= 1'b1;
      segWrIdx <= x;
      segWrSel <= s;
      segWrBase <= b;
      segWrLimit <= l;
      @(posedge clk);
      segWrEn <= 1'b0;
   endtask

   task automatic t_real;
      seg(SEG_DATA, 16'h1234, 32'h0, 32'h0);
      ea(32'h100, 32'hF0);
      indexEn <= 1'b1;
      indexVal <= 32'h10;
      scale <= 2'h3;
      dispSize <= DISP_8;
      req(REF_DATA);
      `CHK(busAddr, 32'h124B0)
      `CHK(busValid, 1'b1)
      ea(32'hFFF0, 32'h20);
      indexEn <= 1'b0;
      dispSize <= DISP_16;
      req(REF_DATA);
      `CHK({protFault, busValid, busAddr}, {2'b10, 32'h124B0})
      // 16-bit wrap keeps the same sum legal
      ea(32'hFFF0, 32'h20);
      addr16 <= 1'b1;
      req(REF_DATA);
      `CHK({protFault, busAddr}, {1'b0, 32'h12350})
   endtask

   task automatic t_prot;
      seg(SEG_DATA, 16'h0008, 32'h40000000, 32'h0000FFFF);
      ea(32'h200, 32'h0);
      protMode <= 1'b1;
      addr16 <= 1'b0;
      dispSize <= DISP_32;
      req(REF_DATA);
      `CHK(busAddr, 32'h40000200)
      seg(SEG_DATA, 16'h0008, 32'h0, 32'h0);
      ea(32'h0, 32'h0);
      req(REF_DATA);
      `CHK({protFault, busValid, busAddr}, {2'b01, 32'h0})
      ea(32'h0, 32'h0);
      accSize <= SIZE_WORD;
      req(REF_DATA);
      `CHK({protFault, busValid}, 2'b10)
   endtask

   task automatic t_sel;
      for (int z = 0; z < 2; z++)
      begin
         for (int k = 0; k < NUM_SEG; k++)
            seg(3'(k), 16'h0, sb(z, k), 32'hFFFFFFFF);
         ea(32'h40, 32'h0);
         accSize <= SIZE_BYTE;
         ipVal <= 32'h100;
         destIdx <= 32'h30;
         overrideEn <= 1'b1;
         overrideSeg <= SEG_DATA;
         req(REF_CODE);
         `CHK(busAddr, sb(z, SEG_CODE) + 32'h100)
         ea(32'h40, 32'h0);
         req(REF_STR_DST);
         `CHK({segUsed, busAddr}, {SEG_EXTRA, sb(z, 0) + 32'h30})
         ea(32'h40, 32'h0);
         req(REF_PUSH);
         `CHK(segUsed, SEG_STACK)
         ea(32'h40, 32'h0);
         req(REF_POP);
         `CHK(segUsed, SEG_STACK)
         for (int b = 0; b < 8; b++)
         begin
            ea(32'h40, 32'h0);
            overrideEn <= 1'b0;
            baseSel <= 3'(b);
            req(REF_DATA);
            want = (b == GP_STACK_PTR || b == GP_FRAME_BASE) ? SEG_STACK
               : SEG_DATA;
            `CHK({segUsed, busAddr}, {want, sb(z, want) + 32'h40})
         end
         for (int k = 0; k < NUM_SEG; k++)
         begin
            ea(32'h40, 32'h0);
            overrideEn <= 1'b1;
            overrideSeg <= 3'(k);
            baseSel <= GP_FRAME_BASE;
            req(REF_DATA);
            `CHK({segUsed, busAddr}, {3'(k), sb(z, k) + 32'h40})
         end
      end
   endtask

   task automatic t_port;
      ea(32'h0, 32'h0);
      pagingOn <= 1'b1;
      portImmEn <= 1'b1;
      portImm <= 8'hF7;
      portAddrReg <= 16'hABCD;
      wrData <= 32'h0000005A;
      req(REF_PORT_RD);
      `CHK({busValid, memIoSel, busAddr}, {2'b10, 32'hF7})
      @(posedge clk);
      portImmEn <= 1'b0;
      req(REF_PORT_WR);
      `CHK({memIoSel, busAddr, byteEn}, {1'b0, 32'hABCD, 4'h2})
      @(posedge clk);
      #1;
      `CHK(i_peer.portByte[16'hABCD], 8'h5A)
      `CHK(i_peer.resvHit, 1'b0)
   endtask

   task automatic t_lanes;
      ea(32'h1001, 32'h0);
      pagingOn <= 1'b0;
      accSize <= SIZE_WORD;
      wrData <= 32'hA1B2C3D4;
      req(REF_DATA);
      `CHK({memIoSel, byteEn, busData}, {5'h16, 32'hB2C3D400})
      ea(32'h2002, 32'h0);
      accSize <= SIZE_DWORD;
      req(REF_DATA);
      `CHK({byteEn, splitNeeded}, {4'hC, 1'b1})
      @(posedge clk);
      #1;
      `CHK(i_peer.memByte[32'h1001], 8'hD4)
      `CHK(i_peer.memByte[32'h1002], 8'hC3)
      `CHK(i_peer.memByte[32'h2002], 8'hD4)
      `CHK(i_peer.memByte[32'h2003], 8'hC3)
   endtask

   task automatic t_data;
      ea(32'h12345678, 32'h0);
      pagingOn <= 1'b1;
      accSize <= SIZE_BYTE;
      req(REF_DATA);
      `CHK({linValid, busValid}, 2'b10)
      `CHK({pageNum, pageOff}, 32'h12345678)
      `CHK(linAddr, 32'h12345678)
      for (int p = 0; p < 8; p++)
         for (int w = 0; w < 34; w++)
         begin
            ea(32'h0, 32'h0);
            pagingOn <= 1'b0;
            fieldPos <= 3'(p);
            fieldWidth <= 6'(w);
            req(REF_DATA);
            n = (p + w + 7) / 8;
            bad = w == 0 || w > 32 || n > 4;
            `CHK(fieldFault, bad)
            if (!bad)
               `CHK(fieldBytes, 3'(n))
         end
      for (int v = 0; v < 256; v++)
      begin
         ea(32'h0, 32'h0);
         wrData <= 32'(v);
         req(REF_DATA);
         `CHK(bcdOk, v[7:4] <= 9 && v[3:0] <= 9)
      end
   endtask

   initial
   begin
      {rst_n, reqValid, protMode, pagingOn, addr16, overrideEn, baseEn,
         indexEn, portImmEn, segWrEn, scale, dispSize, accSize, reqType,
         overrideSeg, baseSel, fieldPos, segWrIdx, fieldWidth, portImm,
         portAddrReg, segWrSel, baseVal, indexVal, disp, ipVal, destIdx,
         wrData, segWrBase, segWrLimit} = '0;
      baseEn = 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_real();
      t_prot();
      t_sel();
      t_port();
      t_lanes();
      t_data();
      wrap_up();
   end
endmodule
